/* bmiu_core.sv */
// Execution unit for the byte move instruction group: registers, memory, status word.
// Assumes a decoded instruction stream with valid/ready, and a memory port that holds
// request until acknowledge, returning read data in the acknowledge cycle.
// How it works
// - Register-immediate load writes the constant into the chosen register; flags kept.
// - Immediate to short direct writes the constant inside the fixed 256-byte window.
// - Immediate to special register stores it; standby control has its own kind.
// - Register-to-register copy within the current bank, flags kept.
// - Accumulator loads from a short direct location.
// - Accumulator stores to a short direct location.
// - Accumulator loads a special register, e.g. received serial byte.
// - Accumulator stores to a special register, e.g. port latch or mode.
// - Page load reads high byte fixed, low byte from the register.
// - Page store writes the accumulator at fixed page plus register.
// - Post-increment page form bumps the low pointer after the transfer.
// - First pointer pair addresses accumulator loads and stores.
// - First pair post-increment form bumps the pair after the transfer.
// - Second pointer pair addresses accumulator loads and stores.
// - Second pair post-increment form bumps the pair after the transfer.
// - Absolute form takes a full 16-bit address from the instruction.
// - Indexed form adds the 16-bit constant and the index register.
// - Status word writes from constant or accumulator replace every flag.
// - All other moves leave zero, auxiliary carry and carry untouched.
// - Short direct address bit 8 is set only below the lower bound.
// - Register codes zero to seven select X, A, C, B, E, D, L, H.
// - Special register space is the top page; its low 32 bytes use short direct.
`timescale 1ns/10ps

module bmiu_core
    import bmiu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Instruction stream
    input wire logic op_valid_i,
    output logic op_ready_o,
    input bmiu_op_type op_kind_i,
    input wire logic [2:0] op_dst_i,
    input wire logic [2:0] op_src_i,
    input wire logic op_postinc_i,
    input wire logic op_index_b_i,
    input wire logic [7:0] op_imm8_i,
    input wire logic [15:0] op_imm16_i,
    output logic op_done_o,
    // Memory and special register space
    output logic mem_req_o,
    output logic mem_we_o,
    output logic [15:0] mem_addr_o,
    output logic [7:0] mem_wdata_o,
    input wire logic [7:0] mem_rdata_i,
    input wire logic mem_ack_i,
    // Status
    output logic [7:0] program_status_word_o,
    output logic [7:0] acc_o,
    output logic standby_control_wr_o
);
    bmiu_state_type state_q;
    logic [7:0] psw_q;
    logic done_q;
    logic stby_q;
    logic we_q;
    logic [15:0] addr_q;
    logic [7:0] wdata_q;
    logic [1:0] pinc_q;
    logic [7:0][7:0] regs;
    logic accept;
    logic complete;
    logic is_mem;
    logic we_d;
    logic [15:0] addr_d;
    logic [7:0] wdata_d;
    logic [1:0] pinc_d;
    logic wr_en;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;
    logic pw_en;
    logic [2:0] pw_hi;
    logic [15:0] pw_data;
    logic [7:0] acc;
    logic [7:0] index_reg;
    logic [15:0] hl_pair;
    logic [15:0] de_pair;
    logic [7:0] sfr_off;

    assign acc = regs[REG_A];
    assign hl_pair = {regs[REG_H], regs[REG_L]};
    assign de_pair = {regs[REG_D], regs[REG_E]};
    assign index_reg = op_index_b_i ? regs[REG_B] : regs[REG_A];
    assign sfr_off = (op_kind_i == OP_STBY_IMM) ? STANDBY_OFFSET : op_imm8_i;
    assign accept = op_valid_i && op_ready_o;
    assign complete = mem_req_o && mem_ack_i;

    // Handshake outputs
    assign op_ready_o = (state_q == ST_IDLE);
    assign mem_req_o = (state_q == ST_ACCESS);

    // Register bank; codes 0..7 map X,A,C,B,E,D,L,H
    bmiu_regbank u_regbank (
        .clk_sys_i(clk_sys_i),
        .rstn_i(rstn_i),
        .bank_i({psw_q[PSW_BANK_HI], psw_q[PSW_BANK_LO]}),
        .wr_en_i(wr_en),
        .wr_idx_i(wr_idx),
        .wr_data_i(wr_data),
        .pw_en_i(pw_en),
        .pw_hi_idx_i(pw_hi),
        .pw_data_i(pw_data),
        .bank_regs_o(regs)
    );

    // Address, direction and post-increment kind of a memory operation
    always_comb
    begin
        is_mem = 1'b1;
        we_d = 1'b0;
        addr_d = 16'h0000;
        wdata_d = acc;
        pinc_d = PINC_NONE;
        unique case (op_kind_i)
            OP_SADDR_IMM, OP_LD_SADDR, OP_ST_SADDR:
            begin
                // Bit 8 set only for offsets under the lower bound
                addr_d = {SADDR_TOP, op_imm8_i < SADDR_LOW_BOUND, op_imm8_i};
                we_d = (op_kind_i != OP_LD_SADDR);
                wdata_d = (op_kind_i == OP_SADDR_IMM) ? op_imm8_i : acc;
            end
            OP_SFR_IMM, OP_STBY_IMM, OP_LD_SFR, OP_ST_SFR:
            begin
                addr_d = {SFR_HIGH, sfr_off};
                we_d = (op_kind_i != OP_LD_SFR);
                wdata_d = (op_kind_i == OP_ST_SFR) ? acc : op_imm8_i;
            end
            OP_LD_PAGE, OP_ST_PAGE:
            begin
                addr_d = {PAGE_HIGH, regs[op_src_i]};
                we_d = (op_kind_i == OP_ST_PAGE);
                pinc_d = op_postinc_i ? PINC_E : PINC_NONE;
            end
            OP_LD_HL, OP_ST_HL:
            begin
                addr_d = hl_pair;
                we_d = (op_kind_i == OP_ST_HL);
                pinc_d = op_postinc_i ? PINC_HL : PINC_NONE;
            end
            OP_LD_DE, OP_ST_DE:
            begin
                addr_d = de_pair;
                we_d = (op_kind_i == OP_ST_DE);
                pinc_d = op_postinc_i ? PINC_DE : PINC_NONE;
            end
            OP_LD_ABS, OP_ST_ABS:
            begin
                addr_d = op_imm16_i;
                we_d = (op_kind_i == OP_ST_ABS);
            end
            OP_LD_IDX, OP_ST_IDX:
            begin
                addr_d = op_imm16_i + {8'h00, index_reg};
                we_d = (op_kind_i == OP_ST_IDX);
            end
            OP_R_IMM, OP_R_R, OP_PSW_IMM, OP_PSW_A, OP_A_PSW:
            begin
                is_mem = 1'b0;
            end
        endcase
    end

    // Sequencer: idle, then hold the request until acknowledged
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= ST_IDLE;
        end
        else if (accept && is_mem)
        begin
            state_q <= ST_ACCESS;
        end
        else if (complete)
        begin
            state_q <= ST_IDLE;
        end
    end

    // Latched memory operation
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            we_q <= 1'b0;
            addr_q <= 16'h0000;
            wdata_q <= 8'h00;
            pinc_q <= PINC_NONE;
            stby_q <= 1'b0;
        end
        else if (accept && is_mem)
        begin
            we_q <= we_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            pinc_q <= pinc_d;
            stby_q <= (op_kind_i == OP_STBY_IMM);
        end
    end

    assign mem_we_o = we_q;
    assign mem_addr_o = addr_q;
    assign mem_wdata_o = wdata_q;

    // Byte writes into the bank: immediates, copies, loads
    always_comb
    begin
        wr_en = 1'b0;
        wr_idx = REG_A;
        wr_data = mem_rdata_i;
        if (complete)
        begin
            wr_en = !we_q;
        end
        else if (accept && op_kind_i == OP_R_IMM)
        begin
            wr_en = 1'b1;
            wr_idx = op_dst_i;
            wr_data = op_imm8_i;
        end
        else if (accept && op_kind_i == OP_R_R)
        begin
            wr_en = 1'b1;
            wr_idx = op_dst_i;
            wr_data = regs[op_src_i];
        end
        else if (accept && op_kind_i == OP_A_PSW)
        begin
            wr_en = 1'b1;
            wr_data = psw_q;
        end
    end

    // Pointer bumps once the transfer is acknowledged, wrapping
    always_comb
    begin
        pw_en = complete && (pinc_q != PINC_NONE);
        pw_hi = REG_D;
        pw_data = {regs[REG_D], regs[REG_E] + 8'h01};
        unique case (pinc_q)
            PINC_HL:
            begin
                pw_hi = REG_H;
                pw_data = hl_pair + 16'h0001;
            end
            PINC_DE:
            begin
                pw_data = de_pair + 16'h0001;
            end
            PINC_NONE, PINC_E:
            begin
                pw_hi = REG_D;
            end
        endcase
    end

    // Status word changes only on its own writes
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            psw_q <= PSW_RESET;
        end
        else if (accept && op_kind_i == OP_PSW_IMM)
        begin
            psw_q <= op_imm8_i;
        end
        else if (accept && op_kind_i == OP_PSW_A)
        begin
            psw_q <= acc;
        end
    end

    // Completion pulse and standby write strobe
    always_ff @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            done_q <= 1'b0;
            standby_control_wr_o <= 1'b0;
        end
        else
        begin
            done_q <= complete || (accept && !is_mem);
            standby_control_wr_o <= complete && stby_q;
        end
    end

    assign op_done_o = done_q;
    assign program_status_word_o = psw_q;
    assign acc_o = acc;

    // Checks
    chk_imm_reg_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_R_IMM |=> regs[$past(op_dst_i)] == $past(op_imm8_i))
        else $error("immediate not in register");
    chk_flags_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !(accept && (op_kind_i == OP_PSW_IMM || op_kind_i == OP_PSW_A)) |=> $stable(psw_q))
        else $error("status word changed by a plain move");
    chk_psw_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_PSW_A |=> psw_q == $past(acc) && op_done_o)
        else $error("status word not replaced");
    chk_saddr_bit: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_LD_SADDR |=> mem_req_o && mem_addr_o[15:9] == SADDR_TOP
        && mem_addr_o[8] == ($past(op_imm8_i) < SADDR_LOW_BOUND))
        else $error("short direct address wrong");
    chk_page_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_LD_PAGE |=> mem_addr_o == {PAGE_HIGH, $past(regs[op_src_i])})
        else $error("page address wrong");
    chk_req_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && !op_ready_o)
        else $error("request dropped before acknowledge");
    chk_load_acc: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        complete && !mem_we_o |=> acc == $past(mem_rdata_i) && op_done_o && op_ready_o)
        else $error("load did not reach accumulator");
    chk_hl_bump: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        complete && pinc_q == PINC_HL |=> hl_pair == $past(hl_pair) + 16'h0001)
        else $error("pair not bumped");
    chk_e_bump: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        complete && pinc_q == PINC_E |=> regs[REG_E] == $past(regs[REG_E]) + 8'h01
        && regs[REG_D] == $past(regs[REG_D]))
        else $error("low pointer not bumped");
    chk_done_pulse: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        op_done_o && !accept |=> !op_done_o)
        else $error("done longer than one cycle");
    chk_sfr_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_LD_SFR |=> mem_addr_o == {SFR_HIGH, $past(op_imm8_i)})
        else $error("special register address wrong");
    chk_abs_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_ST_ABS |=> mem_addr_o == $past(op_imm16_i) && mem_we_o)
        else $error("absolute address wrong");
    chk_idx_addr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        accept && op_kind_i == OP_LD_IDX |=>
        mem_addr_o == $past(op_imm16_i) + {8'h00, $past(index_reg)})
        else $error("indexed address wrong");
endmodule

/* bmiu_regbank.sv */
// Shared constants of the byte move instruction unit, and its general register bank.
// Assumes one clock, an asynchronous active-low reset and a bank number from the status word.
`timescale 1ns/10ps

package bmiu_pkg;
    // Register codes of the current bank
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;
    localparam int NUM_BANKS = 4;
    localparam int REGS_PER_BANK = 8;
    localparam logic [7:0] REG_RESET = 8'h00;
    // Address space windows
    localparam logic [6:0] SADDR_TOP = 7'h7f;
    localparam logic [7:0] SADDR_LOW_BOUND = 8'h20;
    localparam logic [7:0] PAGE_HIGH = 8'hfe;
    localparam logic [7:0] SFR_HIGH = 8'hff;
    localparam logic [7:0] STANDBY_OFFSET = 8'hc0;
    // Status word layout and reset value
    localparam int PSW_CY = 0;
    localparam int PSW_BANK_LO = 3;
    localparam int PSW_AC = 4;
    localparam int PSW_BANK_HI = 5;
    localparam int PSW_Z = 6;
    localparam logic [7:0] PSW_RESET = 8'h00;
    // Post-increment kinds
    localparam logic [1:0] PINC_NONE = 2'h0;
    localparam logic [1:0] PINC_E = 2'h1;
    localparam logic [1:0] PINC_HL = 2'h2;
    localparam logic [1:0] PINC_DE = 2'h3;
    // Instruction kinds of the byte move group
    typedef enum logic [4:0] {
        OP_R_IMM, OP_SADDR_IMM, OP_SFR_IMM, OP_STBY_IMM, OP_R_R,
        OP_LD_SADDR, OP_ST_SADDR, OP_LD_SFR, OP_ST_SFR,
        OP_LD_PAGE, OP_ST_PAGE, OP_LD_HL, OP_ST_HL, OP_LD_DE, OP_ST_DE,
        OP_LD_ABS, OP_ST_ABS, OP_LD_IDX, OP_ST_IDX,
        OP_PSW_IMM, OP_PSW_A, OP_A_PSW
    } bmiu_op_type;
    typedef enum logic [0:0] {ST_IDLE, ST_ACCESS} bmiu_state_type;
endpackage

module bmiu_regbank
    import bmiu_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Bank selection
    input wire logic [1:0] bank_i,
    // Byte write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [7:0] wr_data_i,
    // Pair write port, high register index given, low is one below
    input wire logic pw_en_i,
    input wire logic [2:0] pw_hi_idx_i,
    input wire logic [15:0] pw_data_i,
    // Registers of the current bank
    output logic [7:0][7:0] bank_regs_o
);
    logic [7:0] regs_q [NUM_BANKS*REGS_PER_BANK];

    // One flip-flop byte per entry; pair port wins over byte port on the same entry
    for (genvar g = 0; g < NUM_BANKS * REGS_PER_BANK; g++)
    begin : g_entry
        localparam logic [1:0] BANK = 2'(g / REGS_PER_BANK);
        localparam logic [2:0] IDX = 3'(g % REGS_PER_BANK);
        always_ff @(posedge clk_sys_i or negedge rstn_i)
        begin
            if (!rstn_i)
            begin
                regs_q[g] <= REG_RESET;
            end
            else if (bank_i == BANK)
            begin
                if (pw_en_i && IDX == pw_hi_idx_i)
                begin
                    regs_q[g] <= pw_data_i[15:8];
                end
                else if (pw_en_i && IDX == (pw_hi_idx_i - 3'h1))
                begin
                    regs_q[g] <= pw_data_i[7:0];
                end
                else if (wr_en_i && IDX == wr_idx_i)
                begin
                    regs_q[g] <= wr_data_i;
                end
            end
        end
    end

    // Current bank view
    always_comb
    begin
        for (int i = 0; i < REGS_PER_BANK; i++)
        begin
            bank_regs_o[i] = regs_q[{bank_i, 3'(i)}];
        end
    end
endmodule

/* bmiu_mem_model.sv */
// Behavioural memory and special register space facing the byte move unit.
// Assumes the unit holds each request until ack; ack comes after a settable wait.
`timescale 1ns/10ps

module bmiu_mem_model
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    // Memory port
    input wire logic mem_req_i,
    input wire logic mem_we_i,
    input wire logic [15:0] mem_addr_i,
    input wire logic [7:0] mem_wdata_i,
    output logic [7:0] mem_rdata_o,
    output logic mem_ack_o,
    // Wait cycles before each ack
    input wire logic [3:0] wait_i
);
    logic [7:0] mem [0:65535];
    logic [3:0] cnt_q;

    // One access at a time; read data is only meaningful in the ack cycle
    always @(posedge clk_sys_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            cnt_q <= 4'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 8'h00;
        end
        else if (mem_ack_o)
        begin
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;  // Stale data is scrambled
            if (mem_we_i)
                mem[mem_addr_i] <= mem_wdata_i;
        end
        else if (mem_req_i && cnt_q == wait_i)
        begin
            cnt_q <= 4'h0;
            mem_ack_o <= 1'b1;
            mem_rdata_o <= mem_we_i ? ~mem_rdata_o : mem[mem_addr_i];
        end
        else if (mem_req_i)
            cnt_q <= cnt_q + 4'h1;
    end
endmodule

/* tb_byte_move_instruction_unit.sv */
// Self-checking bench for the byte move execution unit with a memory model behind it.
// Assumes the unit's package and modules are compiled first.
`timescale 1ns/10ps

module tb_byte_move_instruction_unit;
    import bmiu_pkg::*;
    logic clk_sys_i, rstn_i, op_valid_i, op_ready_o, op_postinc_i, op_index_b_i, op_done_o;
    bmiu_op_type op_kind_i;
    logic [2:0] op_dst_i, op_src_i;
    logic [7:0] op_imm8_i, mem_wdata_o, mem_rdata_i, program_status_word_o, acc_o;
    logic [15:0] op_imm16_i, mem_addr_o;
    logic mem_req_o, mem_we_o, mem_ack_i, standby_control_wr_o;
    logic [3:0] wait_q = 4'h0;
    logic [7:0] psw_exp = 8'h00;
    int n_errors = 0;
    int cmp_count = 0;
    int stby_cnt = 0;

    bmiu_core u_bmiu_core (.clk_sys_i, .rstn_i, .op_valid_i, .op_ready_o, .op_kind_i,
        .op_dst_i, .op_src_i, .op_postinc_i, .op_index_b_i, .op_imm8_i, .op_imm16_i,
        .op_done_o, .mem_req_o, .mem_we_o, .mem_addr_o, .mem_wdata_o, .mem_rdata_i,
        .mem_ack_i, .program_status_word_o, .acc_o, .standby_control_wr_o);

    bmiu_mem_model u_bmiu_mem_model (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
        .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i), .mem_ack_o(mem_ack_i),
        .wait_i(wait_q));

    // 20 MHz clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    // Counts standby control write pulses
    always @(posedge clk_sys_i)
        if (standby_control_wr_o === 1'b1)
            stby_cnt++;

    // Compares one value and reports a mismatch
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run
    task automatic summarize();
        $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Issues one instruction, waits for done, checks the status word
    task automatic op(input bmiu_op_type k, input logic [2:0] d, input logic [2:0] s,
                      input logic p, input logic b, input logic [7:0] i8, input logic [15:0] i16);
        int n;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b1;
        op_kind_i <= k;
        op_dst_i <= d;
        op_src_i <= s;
        op_postinc_i <= p;
        op_index_b_i <= b;
        op_imm8_i <= i8;
        op_imm16_i <= i16;
        @(posedge clk_sys_i);
        op_valid_i <= 1'b0;
        for (n = 0; n < 40; n++)
        begin
            @(negedge clk_sys_i);
            if (op_done_o === 1'b1)
                break;
        end
        if (n == 40)
        begin
            n_errors++;
            $display("Error done wait ran out");
            summarize();
        end
        check("status word", {8'h00, program_status_word_o}, {8'h00, psw_exp});
    endtask

    // Loads a register with a constant
    task automatic ldr(input logic [2:0] c, input logic [7:0] v);
        op(OP_R_IMM, c, REG_X, 1'b0, 1'b0, v, 16'h0000);
    endtask

    // Copies a register into the accumulator and checks it
    task automatic rd(input logic [2:0] c, input logic [7:0] e);
        op(OP_R_R, REG_A, c, 1'b0, 1'b0, 8'h00, 16'h0000);
        check("register", {8'h00, acc_o}, {8'h00, e});
    endtask

    // Checks one memory location of the model
    task automatic mck(input logic [15:0] a, input logic [7:0] e);
        check("memory", {8'h00, u_bmiu_mem_model.mem[a]}, {8'h00, e});
    endtask

    // Immediate loads into every register code, read back A to H in order, X last
    task automatic t_regs();
        for (int c = 0; c < 8; c++)
            ldr(3'(c), 8'h10 + 8'(c));
        check("acc", {8'h00, acc_o}, 16'h0011);
        for (int c = 2; c < 8; c++)
            rd(3'(c), 8'h10 + 8'(c));
        rd(REG_X, 8'h10);
        $display("test regs done");
    endtask

    // Status word writes, bank switch, and flags kept by other moves
    task automatic t_psw();
        psw_exp = 8'h51;
        op(OP_PSW_IMM, REG_X, REG_X, 1'b0, 1'b0, 8'h51, 16'h0000);
        op(OP_A_PSW, REG_A, REG_X, 1'b0, 1'b0, 8'h00, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h0051);
        ldr(REG_A, 8'h28);
        psw_exp = 8'h28;
        op(OP_PSW_A, REG_X, REG_X, 1'b0, 1'b0, 8'h00, 16'h0000);
        rd(REG_C, 8'h00);
        psw_exp = 8'h00;
        op(OP_PSW_IMM, REG_X, REG_X, 1'b0, 1'b0, 8'h00, 16'h0000);
        rd(REG_C, 8'h12);
        $display("test status word done");
    endtask

    // Short direct, special register and standby forms with slow acks
    task automatic t_direct();
        wait_q = 4'h2;
        u_bmiu_mem_model.mem[16'hfe80] = 8'ha5;
        u_bmiu_mem_model.mem[16'hff30] = 8'h3c;
        op(OP_LD_SADDR, REG_A, REG_X, 1'b0, 1'b0, 8'h80, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h00a5);
        op(OP_ST_SADDR, REG_X, REG_X, 1'b0, 1'b0, 8'h1f, 16'h0000);
        mck(16'hff1f, 8'ha5);
        op(OP_ST_SADDR, REG_X, REG_X, 1'b0, 1'b0, 8'h20, 16'h0000);
        mck(16'hfe20, 8'ha5);
        op(OP_LD_SFR, REG_A, REG_X, 1'b0, 1'b0, 8'h30, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h003c);
        op(OP_ST_SFR, REG_X, REG_X, 1'b0, 1'b0, 8'h21, 16'h0000);
        mck(16'hff21, 8'h3c);
        op(OP_SADDR_IMM, REG_X, REG_X, 1'b0, 1'b0, 8'h40, 16'h0040);
        mck(16'hfe40, 8'h40);
        op(OP_STBY_IMM, REG_X, REG_X, 1'b0, 1'b0, 8'h5a, 16'h005a);
        mck({SFR_HIGH, STANDBY_OFFSET}, 8'h5a);
        op(OP_SFR_IMM, REG_X, REG_X, 1'b0, 1'b0, 8'h25, 16'h0025);
        mck(16'hff25, 8'h25);
        check("standby pulses", 16'(stby_cnt), 16'h0001);
        $display("test direct done");
    endtask

    // Page forms with pointer wrap on post-increment
    task automatic t_page();
        wait_q = 4'h0;
        ldr(REG_E, 8'hff);
        ldr(REG_D, 8'h33);
        ldr(REG_A, 8'h77);
        op(OP_ST_PAGE, REG_X, REG_E, 1'b1, 1'b0, 8'h00, 16'h0000);
        mck(16'hfeff, 8'h77);
        rd(REG_E, 8'h00);
        rd(REG_D, 8'h33);
        u_bmiu_mem_model.mem[16'hfe33] = 8'h9e;
        op(OP_LD_PAGE, REG_A, REG_D, 1'b0, 1'b0, 8'h00, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h009e);
        $display("test page done");
    endtask

    // Pointer pair forms, plain and post-increment, with wrap
    task automatic t_pairs();
        wait_q = 4'h1;
        ldr(REG_H, 8'hff);
        ldr(REG_L, 8'hff);
        ldr(REG_A, 8'h6b);
        op(OP_ST_HL, REG_X, REG_X, 1'b1, 1'b0, 8'h00, 16'h0000);
        mck(16'hffff, 8'h6b);
        rd(REG_H, 8'h00);
        rd(REG_L, 8'h00);
        u_bmiu_mem_model.mem[16'h0000] = 8'hc4;
        op(OP_LD_HL, REG_A, REG_X, 1'b0, 1'b0, 8'h00, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h00c4);
        rd(REG_L, 8'h00);
        ldr(REG_D, 8'h12);
        ldr(REG_E, 8'h34);
        u_bmiu_mem_model.mem[16'h1234] = 8'he1;
        op(OP_LD_DE, REG_A, REG_X, 1'b1, 1'b0, 8'h00, 16'h0000);
        check("acc", {8'h00, acc_o}, 16'h00e1);
        rd(REG_E, 8'h35);
        rd(REG_D, 8'h12);
        op(OP_ST_DE, REG_X, REG_X, 1'b0, 1'b0, 8'h00, 16'h0000);
        mck(16'h1235, 8'h12);
        $display("test pairs done");
    endtask

    // Absolute and indexed forms with both index registers
    task automatic t_abs_idx();
        wait_q = 4'h3;
        u_bmiu_mem_model.mem[16'h0500] = 8'h81;
        op(OP_LD_ABS, REG_A, REG_X, 1'b0, 1'b0, 8'h00, 16'h0500);
        check("acc", {8'h00, acc_o}, 16'h0081);
        op(OP_ST_ABS, REG_X, REG_X, 1'b0, 1'b0, 8'h00, 16'hbeef);
        mck(16'hbeef, 8'h81);
        ldr(REG_B, 8'h08);
        u_bmiu_mem_model.mem[16'hfe58] = 8'h2d;
        op(OP_LD_IDX, REG_A, REG_X, 1'b0, 1'b1, 8'h00, 16'hfe50);
        check("acc", {8'h00, acc_o}, 16'h002d);
        op(OP_ST_IDX, REG_X, REG_X, 1'b0, 1'b0, 8'h00, 16'h1000);
        mck(16'h102d, 8'h2d);
        $display("test absolute and indexed done");
    endtask

    // Mid-run reset returns status word and registers to zero
    task automatic t_reset();
        @(posedge clk_sys_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        check("status after reset", {8'h00, program_status_word_o}, 16'h0000);
        check("acc after reset", {8'h00, acc_o}, 16'h0000);
        psw_exp = 8'h00;
        rd(REG_H, 8'h00);
        $display("test reset done");
    endtask

    // Reset, then every scenario in turn
    initial
    begin
        rstn_i = 1'b0;
        op_valid_i = 1'b0;
        op_kind_i = OP_R_IMM;
        op_dst_i = 3'h0;
        op_src_i = 3'h0;
        op_postinc_i = 1'b0;
        op_index_b_i = 1'b0;
        op_imm8_i = 8'h00;
        op_imm16_i = 16'h0000;
        repeat (20) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        @(negedge clk_sys_i);
        check("ready after reset", {15'h0000, op_ready_o}, 16'h0001);
        check("request after reset", {15'h0000, mem_req_o}, 16'h0000);
        check("acc after reset", {8'h00, acc_o}, 16'h0000);
        t_regs();
        t_psw();
        t_direct();
        t_page();
        t_pairs();
        t_abs_idx();
        t_reset();
        summarize();
    end
endmodule
